/* File: core/rcb_pkg.sv */
// Shared widths, reset values and timing counts for the command buffer
package rcb_pkg;
  // Gated address and command lines
  localparam int unsigned DATA_W = 21;
  // Paired ungated lines and chip selects
  localparam int unsigned PAIR_W = 2;
  // Reset value of the gated data outputs
  localparam logic [DATA_W-1:0] DATA_RST = 21'h0;
  // Reset value of each paired output group
  localparam logic [PAIR_W-1:0] PAIR_RST = 2'h0;
  // Reset value of the chip select outputs
  localparam logic [PAIR_W-1:0] CS_RST = 2'h0;
  // Gating assumed on until the strap is sampled
  localparam logic GATE_RST = 1'b1;
  // Stages in the reset release and strap synchronisers
  localparam int unsigned SYNC_STAGES = 2;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Cycles the error flag stays low per event
  localparam int unsigned ERR_HOLD_CYC = 2;
  // Extra cycles of delay after the basic parity check
  localparam int unsigned ERR_EXTRA_DLY = 1;
  // Edges from input capture to the error pin driving low
  localparam int unsigned ERR_LATENCY = 1 + ERR_EXTRA_DLY;
endpackage : rcb_pkg

/* File: core/rcb_chk_if.sv */
`timescale 1ns/1ps
// Carries captured bits from the buffer to the parity checker
interface rcb_chk_if;
  // Gated data as captured on the checked edge
  logic [rcb_pkg::DATA_W-1:0] data;
  // Parity bit captured on the same edge
  logic par;
  // High when the capture had a chip select low
  logic valid;
  // Basic check result, one cycle after capture
  logic err;
  // Buffer side
  modport buf_mp (output data, output par, output valid, input err);
  // Checker side
  modport chk_mp (input data, input par, input valid, output err);
endinterface : rcb_chk_if

/* File: core/rcb_parity_chk.sv */
`timescale 1ns/1ps
// Basic odd parity check on one captured command word
module rcb_parity_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  rcb_chk_if.chk_mp chk
);

  // Basic check result
  logic err_reg;

  // Even count of ones across data and parity is a mismatch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= chk.valid & ~(^{chk.data, chk.par});
    end
  end

  assign chk.err = err_reg;

  // Checks of the basic parity result
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_even_flags: assert property (
    chk.valid && !(^{chk.data, chk.par}) |=> chk.err)
    else $error("even parity not flagged");

  chk_odd_quiet: assert property (
    chk.valid && (^{chk.data, chk.par}) |=> !chk.err)
    else $error("odd parity flagged");

  chk_idle_quiet: assert property (
    !chk.valid |=> !chk.err)
    else $error("flag without a checked capture");

endmodule : rcb_parity_chk

/* File: core/rcb_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - Clock enable and termination registered every edge
// - Gated data redriven only with chip select when gating on
// - Gating on: capture when a select low
// - Gating off: capture gated data every edge
// - Outputs update after edge, hold until next
// - All registers use rising positive clock edge
// - Open-drain error pin pulled low on mismatch
// - Error pin stays low two cycles
// - Error indication delayed one extra cycle
// - Async reset clears registers except strap sync (set high); buffer outputs low
// - Reset beats gating, error pin released
// - Both selects high with gating: data holds
module rcb_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic select_gating_on_i,
  input wire logic chip_sel_in_0_i,
  input wire logic chip_sel_in_1_i,
  input wire logic clk_en_in_0_i,
  input wire logic clk_en_in_1_i,
  input wire logic term_in_0_i,
  input wire logic term_in_1_i,
  input wire logic [rcb_pkg::DATA_W-1:0] gated_data_in_i,
  input wire logic parity_bit_in_i,
  input wire logic parity_fail_n_i,
  output logic [rcb_pkg::DATA_W-1:0] gated_data_out_o,
  output logic [rcb_pkg::PAIR_W-1:0] chip_sel_out_o,
  output logic [rcb_pkg::PAIR_W-1:0] clk_en_out_o,
  output logic [rcb_pkg::PAIR_W-1:0] term_out_o,
  output logic parity_fail_n_o,
  output logic parity_fail_oe_o
);

  // Reset release synchroniser, cleared at once
  logic [rcb_pkg::SYNC_STAGES-1:0] rst_pipe_reg;
  // Strap synchroniser for the gating tie-off
  logic [rcb_pkg::SYNC_STAGES-1:0] gate_pipe_reg;
  // High once reset release has settled
  logic run;
  // Synchronised gating strap
  logic gate_on;
  // Any chip select low in this cycle
  logic cs_any;
  // Gated data load enable
  logic data_load;
  // Output registers
  logic [rcb_pkg::DATA_W-1:0] data_out_reg;
  logic [rcb_pkg::PAIR_W-1:0] cs_out_reg;
  logic [rcb_pkg::PAIR_W-1:0] cke_out_reg;
  logic [rcb_pkg::PAIR_W-1:0] term_out_reg;
  // Parity bit and check qualifier for the checker
  logic par_cap_reg;
  logic chk_valid_reg;
  // Error pin drive and second-cycle hold
  logic fail_oe_reg;
  logic fail_hold_reg;
  // Link to the parity checker
  rcb_chk_if chk_link ();

  // Reset asserts at once and releases after two edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_reg <= '0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  // Strap is a static pin, resampled on every edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_pipe_reg <= {rcb_pkg::SYNC_STAGES{rcb_pkg::GATE_RST}};
    end else begin
      gate_pipe_reg <= {gate_pipe_reg[0], select_gating_on_i};
    end
  end

  // Only the last stages are read by logic
  assign run = rst_pipe_reg[rcb_pkg::SYNC_STAGES-1];
  assign gate_on = gate_pipe_reg[rcb_pkg::SYNC_STAGES-1];
  assign cs_any = !chip_sel_in_0_i || !chip_sel_in_1_i;
  // Load gated data when gating is off or a select is low
  assign data_load = run && (!gate_on || cs_any);

  // Ungated pairs and chip selects follow every edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_out_reg <= rcb_pkg::CS_RST;
      cke_out_reg <= rcb_pkg::PAIR_RST;
      term_out_reg <= rcb_pkg::PAIR_RST;
    end else if (run) begin
      cs_out_reg <= {chip_sel_in_1_i, chip_sel_in_0_i};
      cke_out_reg <= {clk_en_in_1_i, clk_en_in_0_i};
      term_out_reg <= {term_in_1_i, term_in_0_i};
    end
  end

  // Gated data: loaded when enabled, otherwise held
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_out_reg <= rcb_pkg::DATA_RST;
    end else if (data_load) begin
      data_out_reg <= gated_data_in_i;
    end
  end

  // Parity is checked only on edges with a select low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_cap_reg <= 1'b0;
      chk_valid_reg <= 1'b0;
    end else begin
      par_cap_reg <= parity_bit_in_i;
      chk_valid_reg <= run && cs_any;
    end
  end

  // Checker sees data captured beside the parity bit
  assign chk_link.data = (chk_valid_reg) ? data_out_reg : rcb_pkg::DATA_RST;
  assign chk_link.par = par_cap_reg;
  assign chk_link.valid = chk_valid_reg;

  // Basic one-cycle parity check
  rcb_parity_chk u_parity_chk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .chk(chk_link.chk_mp)
  );

  // Extra stage before the pin, then two cycles low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fail_oe_reg <= 1'b0;
      fail_hold_reg <= 1'b0;
    end else if (chk_link.err) begin
      fail_oe_reg <= 1'b1;
      fail_hold_reg <= 1'b1;
    end else if (fail_hold_reg) begin
      fail_oe_reg <= 1'b1;
      fail_hold_reg <= 1'b0;
    end else begin
      fail_oe_reg <= 1'b0;
    end
  end

  // Outputs straight from registers
  assign gated_data_out_o = data_out_reg;
  assign chip_sel_out_o = cs_out_reg;
  assign clk_en_out_o = cke_out_reg;
  assign term_out_o = term_out_reg;
  // Active-low flag mirrors the open-drain enable
  assign parity_fail_n_o = ~fail_oe_reg;
  assign parity_fail_oe_o = fail_oe_reg;

  // Checks on the buffer, clocked on the rising edge
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!run);

  chk_ungated_follow: assert property (
    run |=> clk_en_out_o == $past({clk_en_in_1_i, clk_en_in_0_i})
      && term_out_o == $past({term_in_1_i, term_in_0_i}))
    else $error("ungated outputs did not follow inputs");

  chk_select_follow: assert property (
    run |=> chip_sel_out_o == $past({chip_sel_in_1_i, chip_sel_in_0_i}))
    else $error("chip select outputs did not follow");

  chk_gated_load: assert property (
    gate_on && cs_any |=> gated_data_out_o == $past(gated_data_in_i))
    else $error("gated data not loaded with select low");

  chk_ungated_load: assert property (
    !gate_on |=> gated_data_out_o == $past(gated_data_in_i))
    else $error("data not loaded with gating off");

  chk_gated_hold: assert property (
    gate_on && !cs_any |=> $stable(gated_data_out_o))
    else $error("gated data changed with selects high");

  chk_data_stable: assert property (
    gated_data_out_o != $past(gated_data_out_o)
      |-> $past(!gate_on) || $past(cs_any))
    else $error("data changed without a load");

  chk_err_latency: assert property (
    cs_any && !(^{gated_data_in_i, parity_bit_in_i})
      |-> ##3 parity_fail_oe_o && !parity_fail_n_o)
    else $error("error pin not low three samples later");

  chk_err_early: assert property (
    $rose(parity_fail_oe_o) |-> $past(chk_link.err))
    else $error("error pin low without delayed check");

  chk_err_two: assert property (
    $rose(parity_fail_oe_o) |=> parity_fail_oe_o)
    else $error("error pin low for under two cycles");

  chk_err_ends: assert property (
    parity_fail_oe_o && $past(parity_fail_oe_o) && !$past(chk_link.err)
      && !chk_link.err |=> !parity_fail_oe_o)
    else $error("error pin low past its hold");

  chk_reset_clear: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !rst_n_i && !$past(rst_n_i) |-> gated_data_out_o == '0
      && chip_sel_out_o == '0 && clk_en_out_o == '0 && term_out_o == '0)
    else $error("outputs not low during reset");

  chk_reset_release: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !rst_n_i && !$past(rst_n_i) |-> parity_fail_n_o && !parity_fail_oe_o)
    else $error("error pin not released in reset");

  // Main scenarios
  cov_gated_hold: cover property (gate_on && !cs_any ##1 cs_any);
  cov_ungated: cover property (!gate_on && !cs_any);
  cov_err_pulse: cover property ($rose(parity_fail_oe_o) ##2 !parity_fail_oe_o);
  cov_err_wire: cover property (!parity_fail_n_i);

endmodule : rcb_top

/* File: tb/rcb_ctrl_model.sv */
`timescale 1ns/1ps
// Controller side: turns bench commands into pin levels with parity
module rcb_ctrl_model (
  input wire logic [rcb_pkg::DATA_W-1:0] cmd_data_i,
  input wire logic [1:0] cmd_sel_n_i,
  input wire logic [3:0] cmd_pair_i,
  input wire logic cmd_bad_i,
  output logic [rcb_pkg::DATA_W-1:0] data_o,
  output logic par_o,
  output logic [1:0] sel_n_o,
  output logic [3:0] pair_o
);
  // Word and selects pass straight to the pins
  assign data_o = cmd_data_i;
  assign sel_n_o = cmd_sel_n_i;
  assign pair_o = cmd_pair_i;
  // Odd parity over the word; a bad command flips it on purpose
  // Bad flag on an all-zero word gives a low parity bit after reset
  assign par_o = ~(^cmd_data_i) ^ cmd_bad_i;
endmodule : rcb_ctrl_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the command buffer
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gate = 1'b1;
  logic [20:0] c_data = 21'h0;
  logic [1:0] c_sel_n = 2'h3;
  logic [3:0] c_pair = 4'h0;
  logic c_bad = 1'b0;
  logic [20:0] m_data;
  logic m_par;
  logic [1:0] m_sel_n;
  logic [3:0] m_pair;
  logic [20:0] q_data;
  logic [1:0] q_sel, q_cke, q_term;
  logic fail_n, fail_oe;
  wire err_wire = fail_oe ? 1'b0 : 1'b1; // Pull-up on the open-drain net
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  rcb_ctrl_model ctrl (.cmd_data_i(c_data), .cmd_sel_n_i(c_sel_n), .cmd_pair_i(c_pair),
    .cmd_bad_i(c_bad), .data_o(m_data), .par_o(m_par), .sel_n_o(m_sel_n), .pair_o(m_pair));
  rcb_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .select_gating_on_i(gate),
    .chip_sel_in_0_i(m_sel_n[0]), .chip_sel_in_1_i(m_sel_n[1]),
    .clk_en_in_0_i(m_pair[0]), .clk_en_in_1_i(m_pair[1]),
    .term_in_0_i(m_pair[2]), .term_in_1_i(m_pair[3]),
    .gated_data_in_i(m_data), .parity_bit_in_i(m_par), .parity_fail_n_i(err_wire),
    .gated_data_out_o(q_data), .chip_sel_out_o(q_sel), .clk_en_out_o(q_cke),
    .term_out_o(q_term), .parity_fail_n_o(fail_n), .parity_fail_oe_o(fail_oe));
  // Clock at 8 ns
  initial forever #4 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic cmp_vec(input string n, input logic [20:0] e, input logic [20:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_vec
  task automatic cmp_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_bit
  // Presents one command at the falling edge
  task automatic send(input logic [20:0] d, input logic [1:0] s, input logic [3:0] p,
                      input logic b);
    @(negedge clk_i);
    c_data = d;
    c_sel_n = s;
    c_pair = p;
    c_bad = b;
  endtask : send
  // Compares all re-driven outputs after the capturing edge
  task automatic check_q(input logic [20:0] d, input logic [1:0] s, input logic [3:0] p);
    @(negedge clk_i);
    cmp_vec("data", d, q_data);
    cmp_vec("sel", {19'h0, s}, {19'h0, q_sel});
    cmp_vec("cke", {19'h0, p[1:0]}, {19'h0, q_cke});
    cmp_vec("term", {19'h0, p[3:2]}, {19'h0, q_term});
  endtask : check_q
  // Error pin over n falling edges, pattern bit 0 first
  task automatic check_err(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(negedge clk_i);
      cmp_bit("fail_n", pat[i], fail_n);
      cmp_bit("err_wire", pat[i], err_wire);
    end
  endtask : check_err
  // Reset entry and release with quiet inputs
  task automatic t_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    c_sel_n = 2'h3;
    c_data = 21'h0;
    c_pair = 4'h0;
    c_bad = 1'b1;
    repeat (8) @(negedge clk_i);
    cmp_vec("rst data", 21'h0, q_data);
    cmp_bit("rst fail_n", 1'b1, fail_n);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask : t_reset
  // Gating on, one select low at a time: words pass
  task automatic t_pass();
    send(21'h1abcde, 2'h2, 4'h9, 1'b0);
    check_q(21'h1abcde, 2'h2, 4'h9);
    send(21'h054321, 2'h1, 4'h6, 1'b0);
    check_q(21'h054321, 2'h1, 4'h6);
    check_err(8'h0f, 4);
  endtask : t_pass
  // Gating on, both selects high: data holds, pairs still move
  task automatic t_hold();
    send(21'h0f0f0f, 2'h3, 4'h3, 1'b1);
    check_q(21'h054321, 2'h3, 4'h3);
    check_err(8'h0f, 4);
  endtask : t_hold
  // Bad parity: pin low for two cycles after one extra cycle
  task automatic t_parity();
    send(21'h000007, 2'h0, 4'h0, 1'b1);
    send(21'h000007, 2'h3, 4'h0, 1'b0);
    @(negedge clk_i);
    check_err(8'h19, 5);
  endtask : t_parity
  // Two bad words back to back: pin held until two cycles after the last
  task automatic t_err_twice();
    send(21'h000003, 2'h1, 4'h0, 1'b1);
    send(21'h100000, 2'h2, 4'h0, 1'b1);
    send(21'h100000, 2'h3, 4'h0, 1'b0);
    check_err(8'h31, 6);
  endtask : t_err_twice
  // Gating off: data loads with both selects high
  task automatic t_nogate();
    @(negedge clk_i);
    gate = 1'b0;
    repeat (5) @(negedge clk_i);
    send(21'h1c0ffe, 2'h3, 4'h0, 1'b0);
    check_q(21'h1c0ffe, 2'h3, 4'h0);
    gate = 1'b1;
    repeat (5) @(negedge clk_i);
  endtask : t_nogate
  // Reset in mid-run acts at once and releases a held error
  task automatic t_async_reset();
    send(21'h000001, 2'h2, 4'hf, 1'b1);
    send(21'h000001, 2'h3, 4'hf, 1'b0);
    repeat (2) @(negedge clk_i);
    cmp_bit("err before reset", 1'b0, fail_n);
    rst_n_i = 1'b0;
    #1;
    cmp_vec("async data", 21'h0, q_data);
    cmp_vec("async pairs", 21'h0, {15'h0, q_sel, q_cke, q_term});
    cmp_bit("async fail_n", 1'b1, err_wire);
    t_reset();
  endtask : t_async_reset
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    t_reset();
    t_pass();
    t_hold();
    t_parity();
    t_err_twice();
    t_nogate();
    t_async_reset();
    t_pass();
    test_done();
  end
endmodule : tb
